// ===== rsi_pkg.sv
// Shared constants and types for the rotate and set-ones instruction block
package rsi_pkg;

  // Opcode fields of the two handled instructions
  localparam logic [5:0]  ROT_OPC       = 6'h10;   // Upper six bits 0100 00
  localparam logic [6:0]  SET_OPC       = 7'h34;   // Upper seven bits 0110 100
  localparam int          DEST_BIT      = 9;       // Destination select position
  localparam int          ACC_BIT       = 8;       // Bank select position
  localparam int          FADR_MSB      = 7;       // File address top bit

  // Address layout
  localparam int          FADR_W        = 8;
  localparam int          BANK_W        = 4;
  localparam int          RF_ADDR_W     = FADR_W + BANK_W;
  localparam logic [3:0]  ACC_LOW_BANK  = 4'h0;    // Access bank, lower half
  localparam logic [3:0]  ACC_HIGH_BANK = 4'hF;    // Access bank, upper half
  localparam logic [7:0]  ALL_ONES      = 8'hFF;

  // Reset values
  localparam logic [7:0]  DATA_RST      = 8'h00;
  localparam logic [11:0] ADDR_RST      = 12'h000;

  // Instruction cycle phases, Gray coded along the fixed ring
  typedef enum logic [1:0]
  {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b11,
    PH_Q4 = 2'b10
  } rsi_phase_e;

  typedef enum logic [1:0]
  {
    OP_NONE = 2'b00,
    OP_ROT  = 2'b01,
    OP_SET  = 2'b11
  } rsi_op_e;

  // Decoded instruction carried from the decode phase to the write phase
  typedef struct packed
  {
    rsi_op_e     op;
    logic        dest_f;
    logic        acc;
    logic [7:0]  fadr;
  } rsi_dec_s;

  localparam rsi_dec_s DEC_RST = '{op: OP_NONE, dest_f: 1'b0, acc: 1'b0, fadr: 8'h00};

  // Split an instruction word into the decoded fields
  function automatic rsi_dec_s rsi_decode(input logic [15:0] word);
    rsi_dec_s d;
    d        = DEC_RST;
    d.acc    = word[ACC_BIT];
    d.fadr   = word[FADR_W-1:0];
    if (word[15:10] == ROT_OPC)
    begin
      d.op     = OP_ROT;
      d.dest_f = word[DEST_BIT];
    end
    else if (word[15:9] == SET_OPC)
    begin
      d.op     = OP_SET;
      d.dest_f = 1'b1;
    end
    return d;
  endfunction : rsi_decode

endpackage : rsi_pkg

// ===== rsi_alu.sv
// Data path for rotate right without carry and set to all ones
`timescale 1ns/100ps
`default_nettype none
module rsi_alu
  import rsi_pkg::*;
(
  input  wire rsi_op_e    op_i,
  input  wire logic [7:0] data_i,
  output logic [7:0]      result_o,
  output logic            neg_o,
  output logic            zero_o
);

  // Rotation moves bit 0 into bit 7; carry is never involved
  always_comb
  begin
    result_o = data_i;
    unique case (op_i)
      OP_ROT:  result_o = {data_i[0], data_i[7:1]};
      OP_SET:  result_o = ALL_ONES;
      OP_NONE: result_o = data_i;
    endcase
    neg_o  = result_o[7];
    zero_o = (result_o == DATA_RST);
  end

endmodule : rsi_alu
`default_nettype wire

// ===== rsi_core.sv
// Decode and execute of rotate-right-no-carry and set-all-ones
// Contract
// - Set-all-ones writes FFh, flags untouched
// - Bank bit zero selects the access bank
// - Bank bit one uses bank select register
// - Rotate right, bit0 to bit7, N Z updated
// - Destination zero to W, one to file
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module rsi_core
  import rsi_pkg::*;
(
  input  wire logic                 REF_CLK_I,
  input  wire logic                 RESET_N_I,
  input  wire logic [15:0]          INSTR_I,
  input  wire logic                 INSTR_VALID_I,
  input  wire logic [BANK_W-1:0]    BANK_SEL_I,
  input  wire logic [7:0]           RF_RDATA_I,
  output logic [RF_ADDR_W-1:0]      RF_ADDR_O,
  output logic                      RF_RD_O,
  output logic                      RF_WR_O,
  output logic [7:0]                RF_WDATA_O,
  output logic                      WREG_WR_O,
  output logic [7:0]                WREG_O,
  output logic                      FLAG_WR_O,
  output logic                      FLAG_N_O,
  output logic                      FLAG_Z_O,
  output logic [1:0]                PHASE_O,
  output logic                      INSTR_HIT_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta_r;
  logic rst_n_r;

  // Async assert, release after two edges so all flops leave reset together
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Execution state

  rsi_phase_e            phase_r,     phase_nxt;
  rsi_dec_s              dec_r,       dec_nxt;
  logic [RF_ADDR_W-1:0]  addr_r,      addr_nxt;
  logic                  rd_r,        rd_nxt;
  logic                  wr_r,        wr_nxt;
  logic [7:0]            wdata_r,     wdata_nxt;
  logic                  wreg_wr_r,   wreg_wr_nxt;
  logic [7:0]            wreg_r,      wreg_nxt;
  logic                  flag_wr_r,   flag_wr_nxt;
  logic                  n_r,         n_nxt;
  logic                  z_r,         z_nxt;
  logic                  hit_r,       hit_nxt;
  rsi_dec_s              dec_in;
  logic [7:0]            alu_res;
  logic                  alu_n;
  logic                  alu_z;

  assign dec_in = rsi_decode(INSTR_I);

  rsi_alu rsi_alu_i
  (
    .op_i     (dec_r.op),
    .data_i   (RF_RDATA_I),
    .result_o (alu_res),
    .neg_o    (alu_n),
    .zero_o   (alu_z)
  );

  // Next values: one phase per clock, the word is taken only in Q1
  always_comb
  begin
    phase_nxt   = phase_r;
    dec_nxt     = dec_r;
    addr_nxt    = addr_r;
    rd_nxt      = 1'b0;
    wr_nxt      = 1'b0;
    wdata_nxt   = wdata_r;
    wreg_wr_nxt = 1'b0;
    wreg_nxt    = wreg_r;
    flag_wr_nxt = 1'b0;
    n_nxt       = n_r;
    z_nxt       = z_r;
    hit_nxt     = 1'b0;
    unique case (phase_r)
      PH_Q1:
      begin
        phase_nxt = PH_Q2;
        dec_nxt   = INSTR_VALID_I ? dec_in : DEC_RST;
        if (INSTR_VALID_I && (dec_in.op != OP_NONE))
        begin
          hit_nxt = 1'b1;
          rd_nxt  = 1'b1;
          if (!dec_in.acc)
          begin
            // Low half maps to bank 0, high half to the top bank
            addr_nxt = {dec_in.fadr[FADR_MSB] ? ACC_HIGH_BANK : ACC_LOW_BANK,
                        dec_in.fadr};
          end
          else
          begin
            addr_nxt = {BANK_SEL_I, dec_in.fadr};
          end
        end
      end
      PH_Q2:
      begin
        phase_nxt = PH_Q3;
      end
      PH_Q3:
      begin
        // Read data stand only in this phase, so the result is caught now
        phase_nxt = PH_Q4;
        if (dec_r.op == OP_ROT)
        begin
          flag_wr_nxt = 1'b1;
          n_nxt       = alu_n;
          z_nxt       = alu_z;
        end
        if (dec_r.op != OP_NONE)
        begin
          if (dec_r.dest_f)
          begin
            wr_nxt    = 1'b1;
            wdata_nxt = alu_res;
          end
          else
          begin
            wreg_wr_nxt = 1'b1;
            wreg_nxt    = alu_res;
          end
        end
      end
      PH_Q4:
      begin
        phase_nxt = PH_Q1;
        dec_nxt   = DEC_RST;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge REF_CLK_I or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      phase_r   <= PH_Q1;
      dec_r     <= DEC_RST;
      addr_r    <= ADDR_RST;
      rd_r      <= 1'b0;
      wr_r      <= 1'b0;
      wdata_r   <= DATA_RST;
      wreg_wr_r <= 1'b0;
      wreg_r    <= DATA_RST;
      flag_wr_r <= 1'b0;
      n_r       <= 1'b0;
      z_r       <= 1'b0;
      hit_r     <= 1'b0;
    end
    else
    begin
      phase_r   <= phase_nxt;
      dec_r     <= dec_nxt;
      addr_r    <= addr_nxt;
      rd_r      <= rd_nxt;
      wr_r      <= wr_nxt;
      wdata_r   <= wdata_nxt;
      wreg_wr_r <= wreg_wr_nxt;
      wreg_r    <= wreg_nxt;
      flag_wr_r <= flag_wr_nxt;
      n_r       <= n_nxt;
      z_r       <= z_nxt;
      hit_r     <= hit_nxt;
    end
  end

  // Outputs come straight from flops
  assign PHASE_O     = phase_r;
  assign RF_ADDR_O   = addr_r;
  assign RF_RD_O     = rd_r;
  assign RF_WR_O     = wr_r;
  assign RF_WDATA_O  = wdata_r;
  assign WREG_WR_O   = wreg_wr_r;
  assign WREG_O      = wreg_r;
  assign FLAG_WR_O   = flag_wr_r;
  assign FLAG_N_O    = n_r;
  assign FLAG_Z_O    = z_r;
  assign INSTR_HIT_O = hit_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!rst_n_r);

  logic q1_take;
  assign q1_take = (phase_r == PH_Q1) && INSTR_VALID_I && (dec_in.op != OP_NONE);

  set_ones_a: assert property (
    (phase_r == PH_Q3) && (dec_r.op == OP_SET)
      |=> RF_WR_O && (RF_WDATA_O == ALL_ONES) && !FLAG_WR_O && !WREG_WR_O)
    else $error("set-all-ones did not write FFh cleanly");

  access_bank_a: assert property (
    q1_take && !INSTR_I[ACC_BIT]
      |=> RF_ADDR_O == {{4{$past(INSTR_I[7])}}, $past(INSTR_I[7:0])})
    else $error("access bank address wrong");

  bank_select_a: assert property (
    q1_take && INSTR_I[ACC_BIT]
      |=> RF_ADDR_O == {$past(BANK_SEL_I), $past(INSTR_I[7:0])})
    else $error("banked address wrong");

  rotate_value_a: assert property (
    (phase_r == PH_Q3) && (dec_r.op == OP_ROT)
      |=> FLAG_WR_O && (FLAG_N_O == $past(RF_RDATA_I[0]))
          && (FLAG_Z_O == ($past(RF_RDATA_I) == DATA_RST))
          && ((RF_WR_O ? RF_WDATA_O : WREG_O)
              == {$past(RF_RDATA_I[0]), $past(RF_RDATA_I[7:1])}))
    else $error("rotate result or flags wrong");

  rotate_dest_a: assert property (
    (phase_r == PH_Q3) && (dec_r.op == OP_ROT)
      |=> (RF_WR_O == $past(dec_r.dest_f)) && (WREG_WR_O == !$past(dec_r.dest_f)))
    else $error("rotate destination wrong");

  phase_order_a: assert property (
    q1_take |=> RF_RD_O && INSTR_HIT_O ##1 !RF_RD_O ##1 (RF_WR_O || WREG_WR_O)
      ##1 (phase_r == PH_Q1) && !RF_WR_O && !WREG_WR_O)
    else $error("instruction phases out of order");

  rot_to_w_c:   cover property (q1_take && (dec_in.op == OP_ROT) && !INSTR_I[DEST_BIT]);
  rot_to_f_c:   cover property (q1_take && (dec_in.op == OP_ROT) && INSTR_I[DEST_BIT]);
  set_banked_c: cover property (q1_take && (dec_in.op == OP_SET) && INSTR_I[ACC_BIT]);
  set_access_c: cover property (q1_take && (dec_in.op == OP_SET) && !INSTR_I[ACC_BIT]);

endmodule : rsi_core
`default_nettype wire

// ===== rsi_core_tb.sv
// Self-checking bench for the rotate and set-ones instruction block
`timescale 1ns/100ps
`default_nettype none
module rsi_core_tb;
  import rsi_pkg::*;

  logic                 clk;
  logic                 rst_n;
  logic [15:0]          instr;
  logic                 instr_vld;
  logic [BANK_W-1:0]    bank;
  logic [7:0]           rdata;
  logic [RF_ADDR_W-1:0] rf_addr;
  logic                 rf_rd;
  logic                 rf_wr;
  logic [7:0]           rf_wdata;
  logic                 wreg_wr;
  logic [7:0]           wreg;
  logic                 flag_wr;
  logic                 flag_n;
  logic                 flag_z;
  logic [1:0]           phase;
  logic                 hit;
  int                   n_fail;
  int                   checks;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and device under test
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  rsi_core rsi_core_i (
    .REF_CLK_I     (clk),
    .RESET_N_I     (rst_n),
    .INSTR_I       (instr),
    .INSTR_VALID_I (instr_vld),
    .BANK_SEL_I    (bank),
    .RF_RDATA_I    (rdata),
    .RF_ADDR_O     (rf_addr),
    .RF_RD_O       (rf_rd),
    .RF_WR_O       (rf_wr),
    .RF_WDATA_O    (rf_wdata),
    .WREG_WR_O     (wreg_wr),
    .WREG_O        (wreg),
    .FLAG_WR_O     (flag_wr),
    .FLAG_N_O      (flag_n),
    .FLAG_Z_O      (flag_z),
    .PHASE_O       (phase),
    .INSTR_HIT_O   (hit)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Expectations and checking helpers
  function automatic logic [11:0] exp_addr(input logic [15:0] w, input logic [3:0] b);
    if (w[8])
      return {b, w[7:0]};
    return {(w[7] ? 4'hF : 4'h0), w[7:0]}; // Access bank splits at 80h
  endfunction : exp_addr

  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  // One instruction cycle; entered mid Q4 it issues back to back
  task automatic run(input logic [15:0] w, input logic v, input logic [3:0] b,
                     input logic [7:0] d);
    logic       rot;
    logic       set;
    logic       fw;
    logic [7:0] res;
    int         k;
    rot = v && (w[15:10] == ROT_OPC);
    set = v && (w[15:9] == SET_OPC);
    fw  = set | (rot & w[9]);
    res = set ? 8'hFF : {d[0], d[7:1]};
    k   = 0;
    // Look at the phase only once it has settled after an edge
    while (phase !== 2'b10 && k < 8)
    begin
      k++;
      @(posedge clk);
      #1;
    end
    chk("phase_sync", 2'b10, phase);
    @(posedge clk);
    instr     <= w;
    instr_vld <= v;
    bank      <= b;
    rdata     <= 8'($urandom);
    @(posedge clk);
    // Scramble inputs so late sampling shows up
    instr_vld <= 1'b0;
    instr     <= 16'($urandom);
    bank      <= 4'($urandom);
    #1;
    chk("phase_q2", 2'b01, phase);
    chk("hit", rot | set, hit);
    chk("rf_rd", rot | set, rf_rd);
    chk("q2_strobes", 3'b000, {rf_wr, wreg_wr, flag_wr});
    if (rot | set)
      chk("rf_addr", exp_addr(w, b), rf_addr);
    @(posedge clk);
    rdata <= d;
    @(posedge clk);
    rdata <= ~d;
    #1;
    chk("phase_q4", 2'b10, phase);
    chk("rf_wr", fw, rf_wr);
    chk("wreg_wr", rot & ~w[9], wreg_wr);
    chk("flag_wr", rot, flag_wr);
    if (fw)
      chk("rf_wdata", res, rf_wdata);
    if (rot & ~w[9])
      chk("wreg", res, wreg);
    if (rot)
      chk("flags", {res[7], res == 8'h00}, {flag_n, flag_z});
  endtask : run

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog, sized well above the few hundred cycles the tests need
  initial
  begin
    #(5000 * 40);
    n_fail++;
    $display("ERROR watchdog expected done seen timeout");
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [15:0] w;
    void'($urandom(32'h769A));
    rst_n     = 1'b0;
    instr     = 16'h0000;
    instr_vld = 1'b0;
    bank      = 4'h0;
    rdata     = 8'h00;
    n_fail    = 0;
    checks    = 0;
    repeat (8) @(posedge clk);
    chk("reset_out", 5'h00, {rf_rd, rf_wr, wreg_wr, flag_wr, hit});
    rst_n <= 1'b1;
    // Corner cases: bank edges, flag extremes, refused words
    run(16'h687F, 1'b1, 4'h3, 8'h5A);
    run(16'h6880, 1'b1, 4'h3, 8'h5A);
    run(16'h69FF, 1'b1, 4'hF, 8'h00);
    run(16'h4212, 1'b1, 4'h5, 8'hD7);
    run(16'h4134, 1'b1, 4'h9, 8'hD7);
    run(16'h4000, 1'b1, 4'h0, 8'h00);
    run(16'h4301, 1'b1, 4'h2, 8'h01);
    run(16'h6880, 1'b0, 4'h1, 8'h33);
    run(16'h4400, 1'b1, 4'h1, 8'h33);
    run(16'h6A00, 1'b1, 4'h1, 8'h33);
    $display("test corner done");
    // Random mix of both instructions and unhandled words
    repeat (64)
    begin
      w = 16'($urandom);
      case ($urandom % 3)
        0: w[15:10] = ROT_OPC;
        1: w[15:9]  = SET_OPC;
        default: ;
      endcase
      run(w, ($urandom % 8) != 0, 4'($urandom), 8'($urandom));
    end
    $display("test random done");
    tally_and_finish();
  end

endmodule : rsi_core_tb
`default_nettype wire
